/* File: adss_map.vh */
`ifndef ADSS_MAP_VH
`define ADSS_MAP_VH
`define ADSS_CSR_OFF 12'h000
`define ADSS_IRQ_STAT_OFF 12'h004
`define ADSS_IRQ_MASK_OFF 12'h008
`define ADSS_CFG_OFF 12'h00C
`define ADSS_FLAG_BIT 7
`define ADSS_IE_BIT 6
`define ADSS_GO_BIT 5
`define ADSS_CSR_RST 8'h00
`define ADSS_CFG_SCAN_BIT 0
`define ADSS_CFG_TRGEN_BIT 1
`define ADSS_EV_END_BIT 0
`define ADSS_EV_START_BIT 1
`define ADSS_EV_BITS 2
`define ADSS_CONV_CYCLES 8'h10
`endif

/* File: adss_conv_seq.v */
`timescale 1ns/1ns
`default_nettype none
`include "adss_map.vh"
// ==========================================
// conversion sequencer stand-in for the analog core
module adss_conv_seq (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [2:0] last_chan,
  output reg chan_done,
  output reg sweep_done,
  output reg [2:0] chan_r
);
  reg [7:0] cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      chan_r <= 3'h0;
      chan_done <= 1'b0;
      sweep_done <= 1'b0;
    end else begin
      chan_done <= 1'b0;
      sweep_done <= 1'b0;
      if (!run) begin
        // a stop abandons the channel in progress
        cnt_r <= 8'h00;
        chan_r <= 3'h0;
      end else if (cnt_r == `ADSS_CONV_CYCLES - 8'h01) begin
        cnt_r <= 8'h00;
        chan_done <= 1'b1;
        if (chan_r == last_chan) begin
          chan_r <= 3'h0;
          sweep_done <= 1'b1;
        end else begin
          chan_r <= chan_r + 3'h1;
        end
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: adss_trig_edge.v */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// rising edge detect for trigger inputs
module adss_trig_edge (
  input wire pclk,
  input wire presetn,
  input wire lvl,
  output wire rise
);
  reg q_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= lvl;
    end
  end
  assign rise = lvl & ~q_r;
endmodule
`default_nettype wire

/* File: adss_ctrl.v */
// Contract
// - transfer controller service clears end flag
// - end interrupt gated by enable bit 6
// - writing go bit 0 stops conversion
// - go bit set starts conversion
// - single mode clears go when done
// - scan mode runs until go cleared
// - software, timer, external pin set go
// - end flag set at conversion end
// - clear flag by read 1 then write 0
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "adss_map.vh"
module adss_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire timer_trigger,
  input wire external_trigger_pin,
  input wire xfer_ack,
  input wire transfer_irq_select,
  input wire xfer_count_nonzero,
  input wire standby,
  input wire module_stop,
  output wire conversion_end_irq,
  output wire irq,
  output reg converting_r,
  output wire [2:0] chan
);
  // ==========================================
  // bus decode
  function addr_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  wire acc_phase;
  wire wr_en;
  wire rd_en;
  wire csr_sel;
  wire stat_sel;
  wire mask_sel;
  wire cfg_sel;
  wire mapped;

  assign acc_phase = psel & penable;
  assign wr_en = acc_phase & pwrite;
  assign rd_en = acc_phase & ~pwrite;
  assign csr_sel = addr_hit(paddr, `ADSS_CSR_OFF);
  assign stat_sel = addr_hit(paddr, `ADSS_IRQ_STAT_OFF);
  assign mask_sel = addr_hit(paddr, `ADSS_IRQ_MASK_OFF);
  assign cfg_sel = addr_hit(paddr, `ADSS_CFG_OFF);
  assign mapped = csr_sel | stat_sel | mask_sel | cfg_sel;
  // zero wait states: every register answers in its access phase
  assign pready = 1'b1;
  assign pslverr = acc_phase & ~mapped;

  // ==========================================
  // control and status
  reg flag_r;
  reg ie_r;
  reg go_r;
  reg flag_seen_r;
  reg [1:0] cfg_r;
  reg [2:0] last_chan_r;
  reg [`ADSS_EV_BITS-1:0] stat_r;
  reg [`ADSS_EV_BITS-1:0] mask_r;
  wire chan_done;
  wire sweep_done;
  wire tmr_rise;
  wire ext_rise;

  wire [1:0] trig_lvl;
  wire [1:0] trig_rise;

  // both trigger sources get the same edge detector
  assign trig_lvl = {external_trigger_pin, timer_trigger};
  genvar ti;
  generate
    for (ti = 0; ti < 2; ti = ti + 1) begin : g_trig
      adss_trig_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(trig_lvl[ti]),
        .rise(trig_rise[ti])
      );
    end
  endgenerate
  assign tmr_rise = trig_rise[0];
  assign ext_rise = trig_rise[1];
  adss_conv_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .run(go_r),
    .last_chan(last_chan_r),
    .chan_done(chan_done),
    .sweep_done(sweep_done),
    .chan_r(chan)
  );

  wire scan;
  wire trg_en;
  wire csr_wr;
  wire csr_rd;
  wire sw_go;
  wire sw_stop;
  wire hw_go;
  wire force_stop;
  wire end_evt;
  wire dtc_clr;
  wire sw_clr;
  wire go_start;
  reg go_nxt;
  reg flag_nxt;
  reg flag_seen_nxt;

  assign scan = cfg_r[`ADSS_CFG_SCAN_BIT];
  assign trg_en = cfg_r[`ADSS_CFG_TRGEN_BIT];
  assign csr_wr = wr_en & csr_sel;
  assign csr_rd = rd_en & csr_sel;
  assign sw_go = csr_wr & pwdata[`ADSS_GO_BIT];
  assign sw_stop = csr_wr & ~pwdata[`ADSS_GO_BIT];
  // triggers act only when enabled, so an idle pin cannot start a run
  assign hw_go = trg_en & (tmr_rise | ext_rise);
  assign force_stop = standby | module_stop;
  assign end_evt = scan ? sweep_done : chan_done;
  assign dtc_clr = xfer_ack & ~transfer_irq_select &
    xfer_count_nonzero;
  // armed only by reading the flag as 1, so a blind 0 write is ignored
  assign sw_clr = csr_wr & ~pwdata[`ADSS_FLAG_BIT] & flag_seen_r;
  assign go_start = (sw_go | hw_go) & ~go_r & ~force_stop;

  // ==========================================
  // start and stop
  // go bit as a two-state machine: waiting or converting
  localparam ST_WAIT = 1'b0;
  localparam ST_RUN = 1'b1;

  always @* begin
    go_nxt = go_r;
    case (go_r)
      ST_WAIT: begin
        if (sw_go | hw_go) begin
          go_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (~scan & chan_done) begin
          go_nxt = ST_WAIT;
        end
      end
      default: go_nxt = ST_WAIT;
    endcase
    // a written 0 or a standby request wins over any start
    if (sw_stop | force_stop) begin
      go_nxt = ST_WAIT;
    end
  end

  // ==========================================
  // end flag

  always @* begin
    flag_nxt = flag_r;
    if (sw_clr | dtc_clr) begin
      flag_nxt = 1'b0;
    end
    // a conversion end in the clearing cycle is kept
    if (end_evt & go_r) begin
      flag_nxt = 1'b1;
    end
  end

  always @* begin
    flag_seen_nxt = flag_seen_r;
    // any control write or a cleared flag disarms the clear
    if (csr_rd) begin
      flag_seen_nxt = flag_r;
    end else if (csr_wr | ~flag_r) begin
      flag_seen_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
      go_r <= ST_WAIT;
      flag_seen_r <= 1'b0;
      converting_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      go_r <= go_nxt;
      // a copy of go for the pin, so the output comes from a flip-flop
      converting_r <= go_nxt;
      flag_seen_r <= flag_seen_nxt;
    end
  end

  // ==========================================
  // enable and configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r <= 1'b0;
    end else if (csr_wr) begin
      // every control write rewrites the enable as well
      ie_r <= pwdata[`ADSS_IE_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 2'h0;
      last_chan_r <= 3'h0;
    end else if (wr_en & cfg_sel) begin
      cfg_r <= pwdata[1:0];
      last_chan_r <= pwdata[10:8];
    end
  end

  // ==========================================
  // interrupt status, write one to clear
  wire [`ADSS_EV_BITS-1:0] ev;
  assign ev[`ADSS_EV_END_BIT] = end_evt & go_r;
  assign ev[`ADSS_EV_START_BIT] = go_start;
  wire st_wr;
  assign st_wr = wr_en & addr_hit(paddr, `ADSS_IRQ_STAT_OFF);
  // set wins, so an event in the clearing cycle is never lost
  genvar gi;
  generate
    for (gi = 0; gi < `ADSS_EV_BITS; gi = gi + 1) begin : g_stat
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          stat_r[gi] <= 1'b1;
        end else if (st_wr & pwdata[gi]) begin
          stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= {`ADSS_EV_BITS{1'b0}};
    end else if (wr_en & addr_hit(paddr, `ADSS_IRQ_MASK_OFF)) begin
      mask_r <= pwdata[`ADSS_EV_BITS-1:0];
    end
  end

  assign conversion_end_irq = flag_r & ie_r;
  // level output, high while any unmasked status bit stands
  assign irq = |(stat_r & mask_r);

  // ==========================================
  // read data
  function [31:0] csr_image;
    input flag;
    input ie;
    input go;
    begin
      csr_image = 32'h00000000;
      csr_image[`ADSS_FLAG_BIT] = flag;
      csr_image[`ADSS_IE_BIT] = ie;
      csr_image[`ADSS_GO_BIT] = go;
    end
  endfunction

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `ADSS_CSR_OFF: rd_nxt = csr_image(flag_r, ie_r, go_r);
      `ADSS_IRQ_STAT_OFF: rd_nxt[`ADSS_EV_BITS-1:0] = stat_r;
      `ADSS_IRQ_MASK_OFF: rd_nxt[`ADSS_EV_BITS-1:0] = mask_r;
      `ADSS_CFG_OFF: begin
        rd_nxt[1:0] = cfg_r;
        rd_nxt[10:8] = last_chan_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // data captured in setup so it is stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: adss_ctrl_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checks for the converter control block
module adss_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xfer_ack,
  input wire logic transfer_irq_select,
  input wire logic xfer_count_nonzero,
  input wire logic standby,
  input wire logic module_stop,
  input wire logic conversion_end_irq,
  input wire logic converting_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  wire logic csr_wr = acc && pwrite && paddr == 12'h000;
  sequence s_csr_wr;
    csr_wr;
  endsequence
  a_go_start: assert property (
    s_csr_wr ##0 pwdata[5] && !standby && !module_stop |=> converting_r)
    else $error("go bit not set by write");
  a_go_stop: assert property (
    s_csr_wr ##0 !pwdata[5] |=> !converting_r)
    else $error("go bit not cleared by write");
  a_idle_stop: assert property (
    standby || module_stop |=> !converting_r)
    else $error("conversion kept running in standby");
  a_ie_gate: assert property (
    s_csr_wr ##0 !pwdata[6] |=> !conversion_end_irq)
    else $error("end interrupt without enable");
  a_xfer_clear: assert property (
    xfer_ack && !transfer_irq_select && xfer_count_nonzero
    && !converting_r |=> !conversion_end_irq)
    else $error("transfer service left flag set");
  a_flag_hold: assert property (
    conversion_end_irq && !xfer_ack && !csr_wr |=> conversion_end_irq)
    else $error("end interrupt dropped by itself");
  a_end_rise: assert property (
    $rose(conversion_end_irq) |-> $past(converting_r) || $past(acc))
    else $error("end flag set without conversion");
  a_unmapped: assert property (
    acc && paddr > 12'h00C |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind adss_ctrl adss_chk i_chk (.*);
`default_nettype wire

/* File: adss_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench for the converter control block
module adss_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic timer_trigger, external_trigger_pin, xfer_ack, standby;
  logic transfer_irq_select, xfer_count_nonzero, module_stop;
  logic conversion_end_irq, irq, converting_r;
  logic [2:0] chan;
  int fail_count = 0;
  int tests_run = 0;
  adss_ctrl i_adss_ctrl (.*);
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================
  // shared tasks
  task automatic print_verdict;
    $display("checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e,
                    input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // pready is tied high, but the wait stays bounded anyway
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wt(input logic v);
    int n;
    for (n = 0; n < 100 && converting_r !== v; n++) @(posedge pclk);
    if (converting_r !== v) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    bus(1'h0, 12'h000, 32'h0);
    ck("csr", 32'h0, rd);
    bus(1'h0, 12'h010, 32'h0);
    ck("slverr", 32'h1, 32'(err));
    $display("reset test done");
  endtask
  task automatic t_single;
    bus(1'h1, 12'h00C, 32'h0);
    bus(1'h1, 12'h000, 32'h60);
    ck("go", 32'h1, 32'(converting_r));
    wt(1'h0);
    bus(1'h1, 12'h000, 32'h40);
    bus(1'h0, 12'h000, 32'h0);
    ck("csr", 32'hC0, rd);
    ck("end irq", 32'h1, 32'(conversion_end_irq));
    bus(1'h1, 12'h000, 32'h40);
    bus(1'h0, 12'h000, 32'h0);
    ck("csr", 32'h40, rd);
    $display("single test done");
  endtask
  task automatic t_scan;
    int i;
    bus(1'h1, 12'h00C, 32'h101);
    bus(1'h1, 12'h000, 32'h20);
    repeat (80) @(posedge pclk);
    ck("go", 32'h1, 32'(converting_r));
    repeat (8) @(posedge pclk);
    ck("chan", 32'h1, 32'(chan));
    bus(1'h1, 12'h000, 32'h0);
    ck("go", 32'h0, 32'(converting_r));
    bus(1'h0, 12'h000, 32'h0);
    ck("csr", 32'h80, rd);
    for (i = 0; i < 2; i++) begin
      bus(1'h1, 12'h000, 32'h20);
      {module_stop, standby} <= 2'(i + 1);
      @(posedge pclk);
      {module_stop, standby} <= 2'h0;
      @(posedge pclk);
      ck("go", 32'h0, 32'(converting_r));
    end
    bus(1'h0, 12'h000, 32'h0);
    ck("csr", 32'h0, rd);
    $display("scan test done");
  endtask
  task automatic t_trig;
    int i;
    bus(1'h1, 12'h00C, 32'h2);
    for (i = 0; i < 2; i++) begin
      bus(1'h1, 12'h004, 32'h3);
      bus(1'h1, 12'h008, i ? 32'h0 : 32'h3);
      {external_trigger_pin, timer_trigger} <= 2'(i + 1);
      wt(1'h1);
      {external_trigger_pin, timer_trigger} <= 2'h0;
      wt(1'h0);
      ck("irq", 32'(i == 0), 32'(irq));
    end
    $display("trigger test done");
  endtask
  task automatic t_xfer;
    int i;
    bus(1'h1, 12'h00C, 32'h0);
    bus(1'h1, 12'h000, 32'h60);
    wt(1'h0);
    for (i = 0; i < 3; i++) begin
      transfer_irq_select <= (i == 0);
      xfer_count_nonzero <= (i == 2);
      xfer_ack <= 1'h1;
      @(posedge pclk);
      xfer_ack <= 1'h0;
      @(posedge pclk);
      ck("end irq", 32'(i < 2), 32'(conversion_end_irq));
    end
    $display("transfer test done");
  endtask
  initial begin
    {psel, penable, pwrite, timer_trigger, external_trigger_pin} <= 5'h0;
    {xfer_ack, transfer_irq_select, xfer_count_nonzero} <= 3'h0;
    {standby, module_stop, presetn} <= 3'h0;
    paddr <= 12'h0;
    pwdata <= 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_scan();
    t_trig();
    t_xfer();
    print_verdict();
  end
endmodule
`default_nettype wire
